// ===== systm_timer.v
// System timer: periodic tick, watchdog and seconds counter behind APB
`timescale 1ns/1ps
`include "systm_consts.vh"

module systm_timer #(
    parameter FAULT_PIN = 1                       // 1 when the fault pin exists
) (
    input  wire        clk_i,                     // Master clock, 125 MHz
    input  wire        reset_n_i,                 // Async reset, active low
    input  wire        slow_clock_i,              // Slow clock level, sampled
    input  wire        psel_i,                    // APB select
    input  wire        penable_i,                 // APB enable
    input  wire        pwrite_i,                  // APB write
    input  wire [7:0]  paddr_i,                   // APB byte address
    input  wire [31:0] pwdata_i,                  // APB write data
    output reg  [31:0] prdata_o,                  // APB read data
    output reg         pready_o,                  // APB ready
    output reg         pslverr_o,                 // APB error, unmapped address
    output reg         irq_o,                     // Timer interrupt, active high
    output reg         watchdog_fault_out_n_o,    // Watchdog pulse, active low
    output reg         reset_request_o            // Internal reset request pulse
);

// ----------------------------------------------------------------
// Registers and bus decode
// ----------------------------------------------------------------
reg  [15:0] period_reg;
reg  [17:0] wdmode_reg;
reg  [15:0] seconds_prescaler_reg;
reg  [19:0] alarm_reg;
reg  [3:0]  mask_reg;
reg  [3:0]  status_reg;
reg  [3:0]  status_next;
reg  [19:0] rtcount_reg;
reg  [15:0] rtdiv_reg;
reg  [6:0]  wddiv_reg;
reg  [15:0] wdcount_reg;
reg  [3:0]  pulse_reg;
reg         slow_q_reg;
reg  [31:0] rdata_next;
reg         rerr_next;

wire access   = psel_i & penable_i & ~pready_o;
wire wr       = access & pwrite_i;
wire rd       = access & ~pwrite_i;
wire slow_edge = slow_clock_i & ~slow_q_reg;

wire wr_ctrl   = wr && paddr_i == `SYSTM_OFF_CTRL;
wire wr_period = wr && paddr_i == `SYSTM_OFF_PERIOD;
wire wr_wdmode = wr && paddr_i == `SYSTM_OFF_WDMODE;
wire wr_rtmode = wr && paddr_i == `SYSTM_OFF_RTMODE;
wire wr_irqen  = wr && paddr_i == `SYSTM_OFF_IRQEN;
wire wr_irqdis = wr && paddr_i == `SYSTM_OFF_IRQDIS;
wire wr_alarm  = wr && paddr_i == `SYSTM_OFF_ALARM;
wire rd_status = rd && paddr_i == `SYSTM_OFF_STATUS;
wire wd_restart = wr_ctrl & pwdata_i[`SYSTM_BIT_WDRESTART];

always @*
begin
    rdata_next = 32'h00000000;
    rerr_next  = 1'b0;
    case (paddr_i)
        `SYSTM_OFF_CTRL:    rdata_next = 32'h00000000;
        `SYSTM_OFF_PERIOD:  rdata_next = {16'h0000, period_reg};
        `SYSTM_OFF_WDMODE:  rdata_next = {14'h0000, wdmode_reg};
        `SYSTM_OFF_RTMODE:  rdata_next = {16'h0000, seconds_prescaler_reg};
        `SYSTM_OFF_STATUS:  rdata_next = {28'h0000000, status_reg};
        `SYSTM_OFF_IRQEN:   rdata_next = 32'h00000000;
        `SYSTM_OFF_IRQDIS:  rdata_next = 32'h00000000;
        `SYSTM_OFF_IRQMASK: rdata_next = {28'h0000000, mask_reg};
        `SYSTM_OFF_ALARM:   rdata_next = {12'h000, alarm_reg};
        `SYSTM_OFF_RTCOUNT: rdata_next = {12'h000, rtcount_reg};
        default:            rerr_next  = 1'b1;
    endcase
end

always @(posedge clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        pready_o  <= 1'b0;
        prdata_o  <= 32'h00000000;
        pslverr_o <= 1'b0;
    end
    else
    begin
        // One wait state: ready the cycle after the access phase opens
        pready_o  <= access;
        pslverr_o <= access & rerr_next;
        if (rd)
            prdata_o <= rdata_next;
    end
end

// ----------------------------------------------------------------
// Configuration registers
// ----------------------------------------------------------------
always @(posedge clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        period_reg <= `SYSTM_RST_PERIOD;
        wdmode_reg <= `SYSTM_RST_WDMODE;
        seconds_prescaler_reg <= `SYSTM_RST_SECONDS_PRESCALER;
        alarm_reg  <= `SYSTM_RST_ALARM;
        mask_reg   <= 4'h0;
    end
    else
    begin
        if (wr_period)
            period_reg <= pwdata_i[15:0];
        if (wr_wdmode)
            wdmode_reg <= pwdata_i[17:0];
        if (wr_rtmode)
            seconds_prescaler_reg <= pwdata_i[15:0];
        if (wr_alarm)
            alarm_reg <= pwdata_i[19:0];
        if (wr_irqen)
            mask_reg <= mask_reg | pwdata_i[3:0];
        else if (wr_irqdis)
            mask_reg <= mask_reg & ~pwdata_i[3:0];
    end
end

// ----------------------------------------------------------------
// Periodic tick timer
// ----------------------------------------------------------------
wire tick_zero;

systm_down16 u_tick (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .step_i    (slow_edge),
    .load_i    (wr_period),
    .value_i   (wr_period ? pwdata_i[15:0] : period_reg),
    .zero_o    (tick_zero)
);

// ----------------------------------------------------------------
// Watchdog
// ----------------------------------------------------------------
wire wd_step = slow_edge && wddiv_reg == `SYSTM_WD_DIV;
wire wd_over = wd_step && (wdcount_reg == 16'h0001 ||
               (wdcount_reg == 16'h0000 && wdmode_reg[15:0] == 16'h0001));

always @(posedge clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        wddiv_reg   <= 7'h00;
        wdcount_reg <= 16'h0000;
    end
    else if (wd_restart)
    begin
        wddiv_reg   <= 7'h00;
        wdcount_reg <= wdmode_reg[15:0];
    end
    else
    begin
        if (slow_edge)
            wddiv_reg <= wddiv_reg + 7'h01;
        if (wd_over)
            wdcount_reg <= wdmode_reg[15:0];
        else if (wd_step)
            wdcount_reg <= wdcount_reg - 16'h0001;
    end
end

always @(posedge clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        pulse_reg              <= 4'h0;
        watchdog_fault_out_n_o <= 1'b1;
        reset_request_o        <= 1'b0;
    end
    else
    begin
        reset_request_o <= wd_over & wdmode_reg[`SYSTM_BIT_INTERNAL_RESET_ENABLE];
        if (wd_over && wdmode_reg[`SYSTM_BIT_EXTERNAL_PULSE_ENABLE] && FAULT_PIN != 0)
            pulse_reg <= `SYSTM_PULSE_LEN;
        else if (slow_edge && pulse_reg != 4'h0)
            pulse_reg <= pulse_reg - 4'h1;
        watchdog_fault_out_n_o <= ~((wd_over && wdmode_reg[`SYSTM_BIT_EXTERNAL_PULSE_ENABLE] &&
                                  FAULT_PIN != 0) || pulse_reg > 4'h1 ||
                                  (pulse_reg == 4'h1 && !slow_edge));
    end
end

// ----------------------------------------------------------------
// Seconds counter and alarm
// ----------------------------------------------------------------
wire rt_inc = slow_edge && !wr_rtmode &&
              (rtdiv_reg == 16'h0001 || (rtdiv_reg == 16'h0000 && seconds_prescaler_reg == 16'h0001));

always @(posedge clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        rtdiv_reg   <= `SYSTM_RST_SECONDS_PRESCALER;
        rtcount_reg <= 20'h00000;
    end
    else if (wr_rtmode)
    begin
        rtdiv_reg   <= pwdata_i[15:0];
        rtcount_reg <= 20'h00000;
    end
    else if (rt_inc)
    begin
        rtdiv_reg   <= seconds_prescaler_reg;
        rtcount_reg <= rtcount_reg + 20'h00001;
    end
    else if (slow_edge)
        rtdiv_reg <= rtdiv_reg - 16'h0001;
end

wire alarm_hit = rt_inc && (rtcount_reg + 20'h00001) == alarm_reg;

// ----------------------------------------------------------------
// Status, mask and interrupt
// ----------------------------------------------------------------
always @*
begin
    status_next = rd_status ? 4'h0 : status_reg;
    if (tick_zero)
        status_next[`SYSTM_ST_TICK] = 1'b1;
    if (wd_over)
        status_next[`SYSTM_ST_WDEXP] = 1'b1;
    if (rt_inc)
        status_next[`SYSTM_ST_INC] = 1'b1;
    if (alarm_hit)
        status_next[`SYSTM_ST_ALARM] = 1'b1;
end

always @(posedge clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        status_reg <= 4'h0;
        slow_q_reg <= 1'b0;
        irq_o      <= 1'b0;
    end
    else
    begin
        status_reg <= status_next;
        slow_q_reg <= slow_clock_i;
        irq_o      <= |(status_next & mask_reg);
    end
end

endmodule

// ===== systm_consts.vh
// Register map, field layout, reset values and timing constants of the system timer
`ifndef SYSTM_CONSTS_VH
`define SYSTM_CONSTS_VH

`define SYSTM_OFF_CTRL      8'h00
`define SYSTM_OFF_PERIOD    8'h04
`define SYSTM_OFF_WDMODE    8'h08
`define SYSTM_OFF_RTMODE    8'h0c
`define SYSTM_OFF_STATUS    8'h10
`define SYSTM_OFF_IRQEN     8'h14
`define SYSTM_OFF_IRQDIS    8'h18
`define SYSTM_OFF_IRQMASK   8'h1c
`define SYSTM_OFF_ALARM     8'h20
`define SYSTM_OFF_RTCOUNT   8'h24

`define SYSTM_BIT_WDRESTART 0
`define SYSTM_BIT_INTERNAL_RESET_ENABLE     16
`define SYSTM_BIT_EXTERNAL_PULSE_ENABLE     17

`define SYSTM_ST_TICK       0
`define SYSTM_ST_WDEXP      1
`define SYSTM_ST_INC        2
`define SYSTM_ST_ALARM      3

`define SYSTM_RST_PERIOD    16'h0000
`define SYSTM_RST_WDMODE    18'h20000
`define SYSTM_RST_SECONDS_PRESCALER    16'h8000
`define SYSTM_RST_ALARM     20'h00000

`define SYSTM_WD_DIV        7'h7f
`define SYSTM_PULSE_LEN     4'h8

`endif

// ===== systm_down16.v
// Reloadable 16-bit down counter that pulses on reaching zero
`timescale 1ns/1ps
module systm_down16 (
    input  wire        clk_i,      // Clock
    input  wire        reset_n_i,  // Async reset, active low
    input  wire        step_i,     // Count step
    input  wire        load_i,     // Load and restart
    input  wire [15:0] value_i,    // Load value, zero means 65536
    output reg         zero_o      // One-cycle pulse on reaching zero
);

reg [15:0] count_reg;

always @(posedge clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        count_reg <= 16'h0000;
        zero_o    <= 1'b0;
    end
    else
    begin
        zero_o <= 1'b0;
        if (load_i)
            count_reg <= value_i;
        else if (step_i)
        begin
            // From 1 to 0 is the event; zero reloads so value 0 spans 65536 steps
            if (count_reg == 16'h0001 || (count_reg == 16'h0000 && value_i == 16'h0001))
            begin
                zero_o    <= 1'b1;
                count_reg <= value_i;
            end
            else
                count_reg <= count_reg - 16'h0001;
        end
    end
end

endmodule

// ===== systm_timer_sva.sv
// Port assertions for the system timer
`timescale 1ns/1ps
module systm_timer_sva (
    input wire        clk_i,                  // Clock
    input wire        reset_n_i,              // Reset
    input wire        slow_clock_i,           // Slow clock
    input wire        psel_i,                 // Select
    input wire        penable_i,              // Enable
    input wire        pwrite_i,               // Write
    input wire [7:0]  paddr_i,                // Address
    input wire [31:0] pwdata_i,               // Write data
    input wire [31:0] prdata_o,               // Read data
    input wire        pready_o,               // Ready
    input wire        pslverr_o,              // Error
    input wire        irq_o,                  // Interrupt
    input wire        watchdog_fault_out_n_o, // Fault pin
    input wire        reset_request_o         // Reset request
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    ready_one_a: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    ready_cause_a: assert property (pready_o |-> $past(psel_i && penable_i))
        else $error("ready without access");
    data_hold_a: assert property (!$stable(prdata_o) |-> pready_o)
        else $error("read data moved outside access");
    err_zero_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("error without ready or with data");
    err_unmapped_a: assert property (psel_i && penable_i && pready_o && paddr_i > 8'h24
        |-> pslverr_o) else $error("unmapped access accepted");
    ok_mapped_a: assert property (psel_i && penable_i && pready_o && paddr_i < 8'h28
        && paddr_i[1:0] == 2'b00 |-> !pslverr_o) else $error("mapped access refused");
    fault_width_a: assert property ($fell(watchdog_fault_out_n_o) |->
        !watchdog_fault_out_n_o [*8]) else $error("fault pulse too short");
    reset_pulse_a: assert property (reset_request_o |=> !reset_request_o)
        else $error("reset request held");
endmodule

bind systm_timer systm_timer_sva chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .slow_clock_i(slow_clock_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o), .reset_request_o(reset_request_o),
    .watchdog_fault_out_n_o(watchdog_fault_out_n_o));

// ===== systm_timer_tb_top.sv
// Self-checking bench for the system timer
`timescale 1ns/1ps
module systm_timer_tb_top;
    reg         clk_i = 0, reset_n_i = 0, slow_clock_i = 0;
    reg         psel_i = 0, penable_i = 0, pwrite_i = 0, e;
    reg  [7:0]  paddr_i = 0;
    reg  [31:0] pwdata_i = 0, q, lf = 32'h9936dc80;
    wire [31:0] prdata_o;
    wire        pready_o, pslverr_o, irq_o, fault_n, rreq;
    integer     mismatches = 0, n_checks = 0, cyc = 0, nf = 0, nr = 0, m, i;
    integer     pv = 0, wdm = 32'h20000, pres = 32'h8000, alm = 0, msk = 0, st = 0;
    integer     pc = 65536, wc = 65536, wd = 0, rc = 0, rdv = 0, ef = 0, er = 0;

    always #4 clk_i = ~clk_i;

    systm_timer uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .slow_clock_i(slow_clock_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .irq_o(irq_o), .watchdog_fault_out_n_o(fault_n),
        .reset_request_o(rreq));

    always @(negedge fault_n) nf = nf + 1;
    always @(posedge rreq) nr = nr + 1;

    // ----------------------------------------
    // Model and helpers
    // ----------------------------------------
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function integer n16(input integer x);
        n16 = (x == 0) ? 65536 : x;
    endfunction

    function integer mrd(input [7:0] a);
        case (a)
            8'h04: mrd = pv;
            8'h08: mrd = wdm;
            8'h0c: mrd = pres;
            8'h10: mrd = st;
            8'h1c: mrd = msk;
            8'h20: mrd = alm;
            8'h24: mrd = rc;
            default: mrd = 0;
        endcase
    endfunction

    task summarize;
    begin
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask

    task chk(input [63:0] nm, input [31:0] ex, input [31:0] got);
    begin
        n_checks = n_checks + 1;
        if (got !== ex)
        begin
            mismatches = mismatches + 1;
            $display("Error %0s expected %h seen %h", nm, ex, got);
        end
    end
    endtask

    task apb(input w, input [7:0] a, input [31:0] d);
    begin
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (w)
        begin
            case (a)
                8'h00: if (d[0]) begin wc = n16(wdm % 65536); wd = 0; end
                8'h04: begin pv = d[15:0]; pc = n16(pv); end
                8'h08: wdm = d[17:0];
                8'h0c: begin pres = d[15:0]; rdv = 0; rc = 0; end
                8'h14: msk = msk | d[3:0];
                8'h18: msk = msk & ~d[3:0];
                8'h20: alm = d[19:0];
                default: ;
            endcase
        end
    end
    endtask

    task rd(input [7:0] a);
    begin
        apb(1'b0, a, 32'h0);
        chk("rdata", mrd(a), q);
        chk("err", a > 8'h24, e);
        if (a == 8'h10)
            st = 0;
        repeat (3) @(posedge clk_i);
        chk("irq", (st & msk) != 0, irq_o);
    end
    endtask

    task tick(input integer n);
    begin
        repeat (n)
        begin
            @(posedge clk_i) slow_clock_i <= 1'b1;
            @(posedge clk_i);
            @(posedge clk_i) slow_clock_i <= 1'b0;
            @(posedge clk_i);
            if (pc == 1) begin st = st | 1; pc = n16(pv); end else pc = pc - 1;
            wd = wd + 1;
            if (wd == 128)
            begin
                wd = 0;
                if (wc == 1)
                begin
                    st = st | 2;
                    wc = n16(wdm % 65536);
                    ef = ef + wdm[17];
                    er = er + wdm[16];
                end
                else
                    wc = wc - 1;
            end
            rdv = rdv + 1;
            if (rdv == n16(pres))
            begin
                rdv = 0;
                rc = (rc + 1) % 1048576;
                st = st | 4;
                if (rc == alm)
                    st = st | 8;
            end
        end
        repeat (4) @(posedge clk_i);
        chk("irq", (st & msk) != 0, irq_o);
        chk("fault", ef, nf);
        chk("rreq", er, nr);
    end
    endtask

    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            summarize;
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (i = 1; i < 11; i = i + 1)
            if (i != 5 && i != 6)
                rd(i * 4);
        apb(1'b1, 8'h24, 32'h5);
        apb(1'b1, 8'h28, 32'h5);
        rd(8'h24);
        apb(1'b1, 8'h00, 32'h1);
        for (m = 0; m < 4; m = m + 1)
        begin
            lf = lfsr(lf);
            apb(1'b1, m[0] ? 8'h18 : 8'h14, {28'h0, lf[3:0]});
            apb(1'b1, 8'h04, {29'h0, lf[6:4]} + 2);
            // Prescaler of at least one slow period, four master cycles
            apb(1'b1, 8'h0c, {30'h0, lf[9:8]} + 1);
            apb(1'b1, 8'h20, {30'h0, lf[11:10]} + 1);
            apb(1'b1, 8'h08, 32'h10000 * m + 1);
            apb(1'b1, 8'h00, 32'h0);
            tick(20);
            rd(8'h10);
            apb(1'b1, 8'h00, 32'h1);
            tick(130);
            rd(8'h24);
            rd(8'h24);
            rd(8'h10);
            rd(8'h10);
        end
        summarize;
    end
endmodule
